// ===== src/cnmt_pkg.sv
// Purpose: Shared types and constants for the network-management state machine
// Assumes: One 25 MHz clock, asynchronous active-high reset
// Notes:   Command codes follow the NMT command specifier byte
package cnmt_pkg;

    // ************************************************************
    // Network-management states
    // ************************************************************
    typedef enum logic [2:0] {
        CNMT_APP_RESET  = 3'b000,
        CNMT_COMM_RESET = 3'b001,
        CNMT_INIT       = 3'b010,
        CNMT_PRE_OP     = 3'b011,
        CNMT_OPER       = 3'b100,
        CNMT_STOPPED    = 3'b101
    } cnmt_state_type;

    // ************************************************************
    // Command specifiers from the master
    // ************************************************************
    localparam logic [7:0] CNMT_CMD_START      = 8'h01;
    localparam logic [7:0] CNMT_CMD_STOP       = 8'h02;
    localparam logic [7:0] CNMT_CMD_PRE_OP     = 8'h80;
    localparam logic [7:0] CNMT_CMD_RESET_NODE = 8'h81;
    localparam logic [7:0] CNMT_CMD_RESET_COMM = 8'h82;

    // Communication object index range; communication reset loads its first 16 entries
    localparam logic [15:0] CNMT_COMM_IDX_FIRST = 16'h1000;
    localparam logic [15:0] CNMT_COMM_IDX_LAST  = 16'h1FFF;
    localparam logic [15:0] CNMT_IDX_STEP       = 16'h0001;

    // Default-parameter memory depth (entries walked during reset)
    localparam int          CNMT_DEF_DEPTH      = 16;
    localparam int          CNMT_DEF_AW         = 4;
    localparam logic [3:0]  CNMT_DEF_LAST       = 4'hF;
    localparam logic [3:0]  CNMT_DEF_ONE        = 4'h1;

    // Boot-up message state byte
    localparam logic [7:0]  CNMT_BOOT_BYTE      = 8'h00;

    // Service permissions driven to the communication objects
    typedef struct packed {
        logic pdo_en;       // Process data exchange allowed
        logic sdo_en;       // Service data access allowed
        logic cfg_en;       // Configuration writes allowed
        logic emcy_en;      // Emergency messages allowed
        logic mon_en;       // Guarding / heartbeat active
    } cnmt_svc_type;

    // One parameter load towards the object directory
    typedef struct packed {
        logic        valid;
        logic [15:0] index;
        logic [31:0] value;
    } cnmt_load_type;

endpackage : cnmt_pkg

// ===== src/cnmt_defmem.sv
// Purpose: Small memory holding default communication parameters
// Assumes: Written by the application, read by the state machine
// Notes:   Read data is registered, one cycle latency
`timescale 1ns/100ps
module cnmt_defmem (
    input  wire logic        clock,    // System clock
    input  wire logic        wr_en,    // Write strobe
    input  wire logic [3:0]  wr_addr,  // Write address
    input  wire logic [31:0] wr_data,  // Write data
    input  wire logic [3:0]  rd_addr,  // Read address
    output logic      [31:0] rd_data   // Registered read data
);

    logic [31:0] mem_q [cnmt_pkg::CNMT_DEF_DEPTH];
    logic [31:0] rd_data_q;

    // ************************************************************
    // Storage and registered read port
    // ************************************************************
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data_q <= mem_q[rd_addr];
    end

    assign rd_data = rd_data_q;

endmodule : cnmt_defmem

// ===== src/cnmt_fsm.sv
// Purpose: Network-management state machine of a CANopen slave node
// Assumes: Commands arrive decoded, one-cycle strobe, already filtered for this node
// Notes:   Profile restore and object setup are handshaken with the application; communication loads are not
//
// Operation
// - After reset the machine starts in application reset before anything else.
// - Application reset restores saved profile data, then moves on to communication reset.
// - A reset-communication command sends the node to communication reset.
// - Communication reset loads defaults for objects 1000H-100FH, then moves to init.
// - Init sets up SDO, PDO, sync, emergency objects and the CAN controller.
// - Init done: enter pre-operational and send one boot-up message.
// - Operational or stopped returns to pre-operational on enter-pre-operational.
// - Pre-operational allows configuration, SDO, emergency and guarding, no PDO.
// - Pre-operational goes to stopped on stop, operational on start.
// - Pre-operational or operational enters stopped on stop command.
// - Stopped refuses configuration and SDO; only guarding or heartbeat stays.
// - Pre-operational or stopped enters operational on start command.
// - Operational allows every function but configuration, PDO and SDO both.
`timescale 1ns/100ps
module cnmt_fsm (
    input  wire logic                   clock,        // 25 MHz system clock
    input  wire logic                   rst,          // Async reset, active high
    input  wire logic                   cmd_valid,    // Command strobe, one cycle
    input  wire logic [7:0]             cmd_code,     // Command specifier
    input  wire logic                   prof_done,    // Profile restore finished
    input  wire logic                   init_done,    // Object setup finished
    input  wire logic                   def_wr_en,    // Default table write strobe
    input  wire logic [3:0]             def_wr_addr,  // Default table write address
    input  wire logic [31:0]            def_wr_data,  // Default table write data
    output logic                        prof_load,    // Request profile restore
    output logic                        init_req,     // Request object and controller setup
    output cnmt_pkg::cnmt_load_type     comm_load,    // Parameter load to object directory
    output logic                        boot_tx,      // Boot-up message pulse
    output logic [7:0]                  boot_data,    // Boot-up message byte
    output cnmt_pkg::cnmt_svc_type      svc,          // Service permissions
    output cnmt_pkg::cnmt_state_type    state         // Current state
);

    // ************************************************************
    // State
    // ************************************************************
    cnmt_pkg::cnmt_state_type state_q, state_d;
    logic [3:0]               ptr_q, ptr_d;
    logic                     rd_pend_q, rd_pend_d;
    logic                     boot_q, boot_d;
    cnmt_pkg::cnmt_load_type  load_q, load_d;
    cnmt_pkg::cnmt_svc_type   svc_q, svc_d;
    logic [31:0]              def_rd;

    // Default parameter table, loaded by the application
    cnmt_defmem u_defmem (
        .clock   (clock),
        .wr_en   (def_wr_en),
        .wr_addr (def_wr_addr),
        .wr_data (def_wr_data),
        .rd_addr (ptr_q),
        .rd_data (def_rd)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        state_d   = state_q;
        ptr_d     = ptr_q;
        rd_pend_d = 1'b0;
        boot_d    = 1'b0;
        load_d    = '0;
        case (state_q)
            cnmt_pkg::CNMT_APP_RESET: begin
                // Wait for the profile restore before touching communication
                if (prof_done) begin
                    state_d = cnmt_pkg::CNMT_COMM_RESET;
                    ptr_d   = '0;
                end
            end
            cnmt_pkg::CNMT_COMM_RESET: begin
                // Read data lags the address by one cycle, so loads trail
                rd_pend_d = 1'b1;
                ptr_d     = ptr_q + cnmt_pkg::CNMT_DEF_ONE;
                if (rd_pend_q) begin
                    load_d.valid = 1'b1;
                    load_d.index = cnmt_pkg::CNMT_COMM_IDX_FIRST
                                   + {12'h000, ptr_q - cnmt_pkg::CNMT_DEF_ONE};
                    load_d.value = def_rd;
                end
                // The pointer wraps past the last entry, so leave only once its data is out
                if (rd_pend_q
                    && (ptr_q - cnmt_pkg::CNMT_DEF_ONE) == cnmt_pkg::CNMT_DEF_LAST) begin
                    state_d   = cnmt_pkg::CNMT_INIT;
                    rd_pend_d = 1'b0;
                    ptr_d     = '0;
                end
            end
            cnmt_pkg::CNMT_INIT: begin
                if (init_done) begin
                    state_d = cnmt_pkg::CNMT_PRE_OP;
                    boot_d  = 1'b1;
                end
            end
            cnmt_pkg::CNMT_PRE_OP: begin
                if (cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_STOP) begin
                    state_d = cnmt_pkg::CNMT_STOPPED;
                end else if (cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_START) begin
                    state_d = cnmt_pkg::CNMT_OPER;
                end
            end
            cnmt_pkg::CNMT_OPER: begin
                if (cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_STOP) begin
                    state_d = cnmt_pkg::CNMT_STOPPED;
                end else if (cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_PRE_OP) begin
                    state_d = cnmt_pkg::CNMT_PRE_OP;
                end
            end
            cnmt_pkg::CNMT_STOPPED: begin
                if (cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_START) begin
                    state_d = cnmt_pkg::CNMT_OPER;
                end else if (cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_PRE_OP) begin
                    state_d = cnmt_pkg::CNMT_PRE_OP;
                end
            end
            default: begin
                state_d = cnmt_pkg::CNMT_APP_RESET;
            end
        endcase
        // Resets override everything once the node has booted
        if (state_q == cnmt_pkg::CNMT_PRE_OP || state_q == cnmt_pkg::CNMT_OPER
            || state_q == cnmt_pkg::CNMT_STOPPED) begin
            if (cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_RESET_NODE) begin
                state_d = cnmt_pkg::CNMT_APP_RESET;
            end else if (cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_RESET_COMM) begin
                state_d = cnmt_pkg::CNMT_COMM_RESET;
                ptr_d   = '0;
            end
        end
    end

    // Service gating follows the next state so it switches with the state
    always_comb begin
        svc_d = '0;
        case (state_d)
            cnmt_pkg::CNMT_PRE_OP: begin
                svc_d.sdo_en  = 1'b1;
                svc_d.cfg_en  = 1'b1;
                svc_d.emcy_en = 1'b1;
                svc_d.mon_en  = 1'b1;
            end
            cnmt_pkg::CNMT_OPER: begin
                svc_d.pdo_en  = 1'b1;
                svc_d.sdo_en  = 1'b1;
                svc_d.emcy_en = 1'b1;
                svc_d.mon_en  = 1'b1;
            end
            cnmt_pkg::CNMT_STOPPED: begin
                svc_d.mon_en  = 1'b1;
            end
            default: begin
                svc_d = '0;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q   <= cnmt_pkg::CNMT_APP_RESET;
            ptr_q     <= '0;
            rd_pend_q <= 1'b0;
            boot_q    <= 1'b0;
            load_q    <= '0;
            svc_q     <= '0;
        end else begin
            state_q   <= state_d;
            ptr_q     <= ptr_d;
            rd_pend_q <= rd_pend_d;
            boot_q    <= boot_d;
            load_q    <= load_d;
            svc_q     <= svc_d;
        end
    end

    // Outputs
    assign state     = state_q;
    assign svc       = svc_q;
    assign boot_tx   = boot_q;
    assign boot_data = cnmt_pkg::CNMT_BOOT_BYTE;
    assign comm_load = load_q;
    assign prof_load = (state_q == cnmt_pkg::CNMT_APP_RESET);
    assign init_req  = (state_q == cnmt_pkg::CNMT_INIT);

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_boot_done;
        state_q == cnmt_pkg::CNMT_INIT && init_done;
    endsequence

    boot_msg_a: assert property (@(posedge clock) disable iff (rst)
        s_boot_done |=> boot_tx && state_q == cnmt_pkg::CNMT_PRE_OP)
        else $error("Boot-up not sent on entry to pre-operational");
    app_next_a: assert property (@(posedge clock) disable iff (rst)
        state_q == cnmt_pkg::CNMT_APP_RESET && prof_done
        |=> state_q == cnmt_pkg::CNMT_COMM_RESET)
        else $error("Application reset did not advance");
    comm_exit_a: assert property (@(posedge clock) disable iff (rst)
        $rose(state_q == cnmt_pkg::CNMT_COMM_RESET)
        |-> ##[1:40] state_q == cnmt_pkg::CNMT_INIT)
        else $error("Communication reset did not finish");
    reset_comm_a: assert property (@(posedge clock) disable iff (rst)
        svc_q.mon_en && cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_RESET_COMM
        |=> state_q == cnmt_pkg::CNMT_COMM_RESET)
        else $error("Reset communication ignored");
    reset_node_a: assert property (@(posedge clock) disable iff (rst)
        svc_q.mon_en && cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_RESET_NODE
        |=> state_q == cnmt_pkg::CNMT_APP_RESET)
        else $error("Reset node ignored");
    stop_cmd_a: assert property (@(posedge clock) disable iff (rst)
        (state_q == cnmt_pkg::CNMT_PRE_OP || state_q == cnmt_pkg::CNMT_OPER)
        && cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_STOP
        |=> state_q == cnmt_pkg::CNMT_STOPPED)
        else $error("Stop command not obeyed");
    start_cmd_a: assert property (@(posedge clock) disable iff (rst)
        (state_q == cnmt_pkg::CNMT_PRE_OP || state_q == cnmt_pkg::CNMT_STOPPED)
        && cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_START
        |=> state_q == cnmt_pkg::CNMT_OPER && svc.pdo_en)
        else $error("Start command not obeyed");
    preop_cmd_a: assert property (@(posedge clock) disable iff (rst)
        (state_q == cnmt_pkg::CNMT_OPER || state_q == cnmt_pkg::CNMT_STOPPED)
        && cmd_valid && cmd_code == cnmt_pkg::CNMT_CMD_PRE_OP
        |=> state_q == cnmt_pkg::CNMT_PRE_OP)
        else $error("Enter pre-operational not obeyed");
    preop_svc_a: assert property (@(posedge clock) disable iff (rst)
        state_q == cnmt_pkg::CNMT_PRE_OP |-> svc.sdo_en && svc.cfg_en && !svc.pdo_en)
        else $error("Pre-operational service gating wrong");
    stop_svc_a: assert property (@(posedge clock) disable iff (rst)
        state_q == cnmt_pkg::CNMT_STOPPED
        |-> svc.mon_en && !svc.sdo_en && !svc.cfg_en && !svc.pdo_en)
        else $error("Stopped service gating wrong");
    oper_svc_a: assert property (@(posedge clock) disable iff (rst)
        state_q == cnmt_pkg::CNMT_OPER |-> svc.pdo_en && svc.sdo_en)
        else $error("Operational service gating wrong");
    first_app_a: assert property (@(posedge clock)
        $fell(rst) |-> state_q == cnmt_pkg::CNMT_APP_RESET)
        else $error("Did not start in application reset");

endmodule : cnmt_fsm

// ===== test/cnmt_master_model.sv
// Purpose: Network master and application model facing the state machine
// Assumes: Commands are sent one at a time through the send task
// Notes:   Done answers wait lag cycles, so the bench can be prompt or slow
`timescale 1ns/100ps
module cnmt_master_model (
    input  wire logic       clock,      // System clock
    input  wire logic       rst,        // Async reset, active high
    input  wire logic [7:0] lag,        // Cycles before a done answer
    input  wire logic       prof_load,  // Profile restore request
    input  wire logic       init_req,   // Object setup request
    output logic            prof_done,  // Profile restore finished
    output logic            init_done,  // Object setup finished
    output logic            cmd_valid,  // Command strobe
    output logic [7:0]      cmd_code    // Command specifier
);
    logic [7:0] wait_q;
    logic [7:0] wait_d;

    // ************************************************************
    // Application answers
    // ************************************************************
    // Count how long the current request has been pending
    always_comb begin
        wait_d = (prof_load || init_req) ? wait_q + 8'h01 : 8'h00;
    end

    // Register the pending count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_q <= 8'h00;
        end else begin
            wait_q <= wait_d;
        end
    end

    // Done drops with the request, so a stale level never leaks into the next state
    assign prof_done = prof_load && (wait_q >= lag);
    assign init_done = init_req && (wait_q >= lag);

    // ************************************************************
    // Command sender
    // ************************************************************
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
    end

    // One command strobe, one clock cycle wide
    task automatic send(input logic [7:0] code);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_code  <= ~code;  // Released bus shows no stale command
    endtask : send
endmodule : cnmt_master_model

// ===== test/canopen_nmt_state_machine_bench.sv
// Purpose: Self-checking bench for the network-management state machine
// Assumes: Master model sends commands and answers profile and init requests
// Notes:   A watchdog fails the run if it is still going after ten thousand cycles
`timescale 1ns/100ps
module canopen_nmt_state_machine_bench;
    logic                     clock, rst, cmd_valid, prof_done, init_done, def_wr_en;
    logic                     prof_load, init_req, boot_tx;
    logic [7:0]               cmd_code, boot_data, lag;
    logic [3:0]               def_wr_addr;
    logic [31:0]              def_wr_data;
    cnmt_pkg::cnmt_load_type  comm_load;
    cnmt_pkg::cnmt_svc_type   svc;
    cnmt_pkg::cnmt_state_type state;
    int                       errors, n_checks, boots, bad_boots;
    logic [15:0]              idx_q[$];
    logic [31:0]              val_q[$];

    cnmt_fsm u_cnmt_fsm (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .prof_done(prof_done), .init_done(init_done), .def_wr_en(def_wr_en),
        .def_wr_addr(def_wr_addr), .def_wr_data(def_wr_data), .prof_load(prof_load),
        .init_req(init_req), .comm_load(comm_load), .boot_tx(boot_tx),
        .boot_data(boot_data), .svc(svc), .state(state));
    cnmt_master_model u_cnmt_master_model (.clock(clock), .rst(rst), .lag(lag),
        .prof_load(prof_load), .init_req(init_req), .prof_done(prof_done),
        .init_done(init_done), .cmd_valid(cmd_valid), .cmd_code(cmd_code));

    // ************************************************************
    // Clock and monitors
    // ************************************************************
    initial clock = 1'b0;
    always #20 clock = ~clock;

    // Collect parameter loads and boot pulses as the design issues them
    always @(posedge clock) begin
        if (comm_load.valid === 1'b1) begin
            idx_q.push_back(comm_load.index);
            val_q.push_back(comm_load.value);
        end
        if (boot_tx === 1'b1) begin
            boots++;
            if (state !== cnmt_pkg::CNMT_PRE_OP || boot_data !== cnmt_pkg::CNMT_BOOT_BYTE)
                bad_boots++;
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Service bits per state; SDO access in operational is left open
    task automatic check_svc();
        logic [4:0] exp;
        logic [4:0] mask;
        mask = (state == cnmt_pkg::CNMT_OPER) ? 5'h17 : 5'h1F;
        case (state)
            cnmt_pkg::CNMT_PRE_OP:  exp = 5'h0F;
            cnmt_pkg::CNMT_OPER:    exp = 5'h1B;
            cnmt_pkg::CNMT_STOPPED: exp = 5'h01;
            default:                exp = 5'h00;
        endcase
        check("svc", 32'(svc & mask), 32'(exp & mask));
    endtask : check_svc

    task automatic cmd(input logic [7:0] code, input cnmt_pkg::cnmt_state_type s);
        u_cnmt_master_model.send(code);
        #1;
        check("state", 32'(state), 32'(s));
        check_svc();
    endtask : cmd

    // Bounded wait; a state that never comes shows up as a mismatch
    task automatic wait_state(input cnmt_pkg::cnmt_state_type s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("state", 32'(state), 32'(s));
    endtask : wait_state

    // From communication reset up to pre-operational, with loads and boot-up
    task automatic walk_up(input int n);
        wait_state(cnmt_pkg::CNMT_COMM_RESET, 60);
        idx_q.delete();
        val_q.delete();
        wait_state(cnmt_pkg::CNMT_INIT, 80);
        check("init_req", 32'(init_req), 32'(1));
        // The last load leaves with the state change; let the monitor take it
        @(posedge clock);
        #1;
        check("loads", idx_q.size(), 16);
        foreach (idx_q[i]) check("index", 32'(idx_q[i]), 32'(16'h1000 + i));
        for (int i = 0; i < 16 && i < val_q.size(); i++)
            check("value", val_q[i], 32'hC0DE_0000 | 32'(i));
        wait_state(cnmt_pkg::CNMT_PRE_OP, 60);
        @(posedge clock);
        #1;
        check("boots", boots, n);
        check("bad_boots", bad_boots, 0);
        check("boot_tx", 32'(boot_tx), 32'(0));
        check_svc();
    endtask : walk_up

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Slow profile restore; table filled and a command refused meanwhile
    task automatic t_boot();
        check("state", 32'(state), 32'(cnmt_pkg::CNMT_APP_RESET));
        check("prof_load", 32'(prof_load), 32'(1));
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            def_wr_en   <= 1'b1;
            def_wr_addr <= 4'(i);
            def_wr_data <= 32'hC0DE_0000 | 32'(i);
        end
        @(posedge clock);
        def_wr_en <= 1'b0;
        cmd(cnmt_pkg::CNMT_CMD_START, cnmt_pkg::CNMT_APP_RESET);
        walk_up(1);
        lag <= 8'h00;
    endtask : t_boot

    // Every defined move among the three running states
    task automatic t_walk();
        logic [7:0] codes [6] = '{cnmt_pkg::CNMT_CMD_START, cnmt_pkg::CNMT_CMD_STOP,
            cnmt_pkg::CNMT_CMD_PRE_OP, cnmt_pkg::CNMT_CMD_STOP, cnmt_pkg::CNMT_CMD_START,
            cnmt_pkg::CNMT_CMD_PRE_OP};
        cnmt_pkg::cnmt_state_type goal [6] = '{cnmt_pkg::CNMT_OPER, cnmt_pkg::CNMT_STOPPED,
            cnmt_pkg::CNMT_PRE_OP, cnmt_pkg::CNMT_STOPPED, cnmt_pkg::CNMT_OPER,
            cnmt_pkg::CNMT_PRE_OP};
        for (int i = 0; i < 6; i++)
            cmd(codes[i], goal[i]);
    endtask : t_walk

    // Commands with no transition, one idle cycle apart, leave the state alone
    task automatic t_ignore();
        cmd(cnmt_pkg::CNMT_CMD_PRE_OP, cnmt_pkg::CNMT_PRE_OP);
        cmd(8'h55, cnmt_pkg::CNMT_PRE_OP);
        cmd(cnmt_pkg::CNMT_CMD_START, cnmt_pkg::CNMT_OPER);
        cmd(cnmt_pkg::CNMT_CMD_START, cnmt_pkg::CNMT_OPER);
        cmd(cnmt_pkg::CNMT_CMD_STOP, cnmt_pkg::CNMT_STOPPED);
        cmd(cnmt_pkg::CNMT_CMD_STOP, cnmt_pkg::CNMT_STOPPED);
    endtask : t_ignore

    // Reset commands and a reset in mid-run, each followed by a full restart
    task automatic t_resets();
        cmd(cnmt_pkg::CNMT_CMD_RESET_COMM, cnmt_pkg::CNMT_COMM_RESET);
        walk_up(2);
        cmd(cnmt_pkg::CNMT_CMD_START, cnmt_pkg::CNMT_OPER);
        cmd(cnmt_pkg::CNMT_CMD_RESET_NODE, cnmt_pkg::CNMT_APP_RESET);
        check("prof_load", 32'(prof_load), 32'(1));
        walk_up(3);
        cmd(cnmt_pkg::CNMT_CMD_START, cnmt_pkg::CNMT_OPER);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("state", 32'(state), 32'(cnmt_pkg::CNMT_APP_RESET));
        check("svc", 32'(svc), 32'(0));
        check("load_valid", 32'(comm_load.valid), 32'(0));
        @(posedge clock);
        rst <= 1'b0;
        walk_up(4);
    endtask : t_resets

    // ************************************************************
    // Run control
    // ************************************************************
    task automatic final_report();
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // Main sequence; slow answers first, prompt ones afterwards
    initial begin
        rst         = 1'b1;
        lag         = 8'h28;
        def_wr_en   = 1'b0;
        def_wr_addr = 4'h0;
        def_wr_data = 32'h0000_0000;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        t_boot();
        t_walk();
        t_ignore();
        t_resets();
        final_report();
    end

    // Watchdog; the whole run needs well under ten thousand cycles
    initial begin
        #400_000;
        errors++;
        final_report();
    end
endmodule : canopen_nmt_state_machine_bench
